// File: hw/eeprom_seq_pkg.sv
// shared constants and types for the eeprom page sequencer and interval timer
package eeprom_seq_pkg;
    // register word offsets (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_REG_OFS = 8'h04;
    localparam logic [7:0] BYTE_PORT_OFS = 8'h0c;
    localparam logic [7:0] CONTROL_REG_OFS = 8'h10;
    localparam logic [7:0] RELOAD_REG_OFS = 8'h14;
    localparam logic [7:0] COUNT_REG_OFS = 8'h18;
    // control register field positions
    localparam int FREE_RUN_POS = 7;
    localparam int IRQ_EN_POS = 6;
    localparam int UFLOW_POS = 5;
    localparam int IN_PROG_POS = 4;
    localparam int OP3_POS = 3;
    localparam int OP2_POS = 2;
    localparam int OP1_POS = 1;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    // prescaler: one decrement per 480 crystal periods
    localparam int PRESCALE_DIV = 480;
    localparam logic [8:0] PRESCALE_LAST = 9'(PRESCALE_DIV - 1);
    localparam logic [1:0] LATCH_LAST = 2'h3;
    localparam int EE_BYTES = 128;
    // op-code values (bits 3..1) with in-progress set
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_ERASE_WRITE = 3'h4;
    localparam logic [2:0] OP_ERASE = 3'h7;

    typedef enum {PH_IDLE, PH_ERASE, PH_WRITE} phase_t;

    // one request from the bus side into the sequencer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] ofs;
        logic [7:0] data;
    } reg_req_t;
endpackage

// File: hw/interval_prescaler.sv
// divide-by-480 tick generator for the interval counter
`timescale 1ns/1ps
module interval_prescaler
    import eeprom_seq_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic restart_i,
    output logic tick_o
);
    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } pre_state_t;

    pre_state_t st_ff;
    pre_state_t nxt_st;

    // restart aligns the first decrement to a full 480-cycle interval
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (restart_i) begin
            nxt_st.cnt = 9'h000;
        end else if (st_ff.cnt == PRESCALE_LAST) begin
            nxt_st.cnt = 9'h000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;
endmodule // interval_prescaler

// File: hw/eeprom_page_sequencer_timer.sv
// eeprom page sequencer with interval down-counter, wishbone register slave
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
// Function
// - byte port write loads indexed latch, sets flag
// - op2-only control word selects increment mode
// - increment mode advances index, stops at three
// - page bits ignored during latch setup
// - byte port read returns byte, increments address
// - write page ORs flagged latches, one interval
// - in-progress plus op2 starts write, counter
// - write advances address, page carry at three
// - erase/write: erase interval, reload, write interval
// - in-progress plus op3 starts erase/write, increments
// - all op bits: erase flagged, address unchanged
// - eight-bit counter decrements every 480 clocks
// - in-progress set loads counter from reload
// - final underflow stops unless free-run set, flags, clears op bits
// - free-run start loads, reloads on underflow
// - clearing free-run holds value, restart reloads
// - counter value readable at any time
// - latches OR-accumulate, cleared at cycle end
// - byte flags cleared at cycle end
// - cycle end raises irq when enabled
module eeprom_page_sequencer_timer
    import eeprom_seq_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // interrupt system side
    input wire logic deriv_irq_enable_i,
    output logic timer_irq_o,
    output logic busy_o
);
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] ctrl;
        logic [7:0] reload;
        logic [7:0] count;
        logic running;
        logic inc_mode;
        phase_t phase;
        logic [3:0][7:0] latch;
        logic [3:0] flags;
        logic [31:0] rdata;
        logic ack;
        logic irq;
    } seq_state_t;

    seq_state_t st_ff;
    seq_state_t nxt_st;
    logic [7:0] mem_ff [EE_BYTES];
    logic tick;
    logic restart;
    logic bus_req;
    reg_req_t req;

    interval_prescaler u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(restart),
        .tick_o(tick)
    );

    // a request is taken once; ack drops the cycle after it is given
    assign bus_req = cyc_i && stb_i && !st_ff.ack;
    assign req.wr = bus_req && we_i && sel_i[0];
    assign req.rd = bus_req && !we_i;
    assign req.ofs = adr_i;
    assign req.data = dat_i[7:0];

    // eeprom byte address of a page byte
    function automatic logic [6:0] page_byte(input logic [6:0] a, input logic [1:0] b);
        page_byte = {a[6:2], b};
    endfunction

    // restart the prescaler whenever the counter is (re)loaded by software
    assign restart = req.wr && req.ofs == CONTROL_REG_OFS
        && (req.data[IN_PROG_POS] || (req.data[FREE_RUN_POS] && !st_ff.ctrl[FREE_RUN_POS]));

    always_comb begin
        logic uflow;
        logic last;
        uflow = 1'b0;
        last = 1'b0;
        nxt_st = st_ff;
        nxt_st.ack = bus_req;
        // counter: underflow is a decrement past zero
        if (st_ff.running && tick) begin
            if (st_ff.count == 8'h00) begin
                uflow = 1'b1;
                nxt_st.count = st_ff.reload;
            end else begin
                nxt_st.count = st_ff.count - 8'h01;
            end
        end
        if (uflow) begin
            if (st_ff.phase == PH_ERASE && st_ff.ctrl[3:1] == OP_ERASE_WRITE) begin
                nxt_st.phase = PH_WRITE;
            end else if (st_ff.phase != PH_IDLE) begin
                last = 1'b1;
            end else begin
                nxt_st.ctrl[UFLOW_POS] = 1'b1;
            end
        end
        // end of an eeprom cycle
        if (last) begin
            nxt_st.running = st_ff.ctrl[FREE_RUN_POS];
            nxt_st.ctrl[UFLOW_POS] = 1'b1;
            nxt_st.ctrl[IN_PROG_POS] = 1'b0;
            nxt_st.ctrl[3:1] = 3'h0;
            nxt_st.phase = PH_IDLE;
            nxt_st.latch = '0;
            nxt_st.flags = 4'h0;
            nxt_st.inc_mode = 1'b0;
            if (st_ff.ctrl[3:1] != OP_ERASE) begin
                nxt_st.addr = {st_ff.addr[6:2], 2'b00} + 7'h04;
                if (st_ff.addr[1:0] != LATCH_LAST) begin
                    nxt_st.addr = st_ff.addr + 7'h01;
                end
            end // erase keeps address
            nxt_st.irq = st_ff.ctrl[IRQ_EN_POS] && deriv_irq_enable_i;
        end else if (!st_ff.ctrl[IRQ_EN_POS] || !st_ff.ctrl[UFLOW_POS]) begin
            nxt_st.irq = 1'b0;
        end
        if (uflow && st_ff.phase == PH_IDLE) begin
            nxt_st.irq = st_ff.ctrl[IRQ_EN_POS] && deriv_irq_enable_i;
        end
        // register writes
        if (req.wr) begin
            case (req.ofs)
                ADDR_REG_OFS: nxt_st.addr = req.data[6:0];
                BYTE_PORT_OFS: begin
                    // page bits play no part in latch choice
                    nxt_st.latch[st_ff.addr[1:0]] = st_ff.latch[st_ff.addr[1:0]]
                        | req.data;
                    nxt_st.flags[st_ff.addr[1:0]] = 1'b1;
                    if (st_ff.inc_mode && st_ff.addr[1:0] != LATCH_LAST) begin
                        nxt_st.addr[1:0] = st_ff.addr[1:0] + 2'h1;
                    end
                end
                CONTROL_REG_OFS: begin
                    nxt_st.ctrl[7:1] = req.data[7:1];
                    // set wins over a clear in the same cycle
                    if (uflow) begin
                        nxt_st.ctrl[UFLOW_POS] = 1'b1;
                    end
                    if (req.data[IN_PROG_POS]) begin
                        nxt_st.count = st_ff.reload;
                        nxt_st.running = 1'b1;
                        nxt_st.inc_mode = 1'b0;
                        case (req.data[3:1])
                            OP_WRITE: nxt_st.phase = PH_WRITE;
                            OP_ERASE_WRITE: nxt_st.phase = PH_ERASE;
                            OP_ERASE: nxt_st.phase = PH_ERASE;
                            default: begin
                                nxt_st.phase = PH_IDLE;
                                nxt_st.running = 1'b0;
                                nxt_st.ctrl[IN_PROG_POS] = 1'b0;
                            end
                        endcase
                    end else begin
                        nxt_st.inc_mode = req.data[3:1] == OP_WRITE;
                        if (req.data[FREE_RUN_POS] && !st_ff.ctrl[FREE_RUN_POS]) begin
                            nxt_st.count = st_ff.reload;
                            nxt_st.running = 1'b1;
                        end else if (!req.data[FREE_RUN_POS] && st_ff.phase == PH_IDLE) begin
                            nxt_st.running = 1'b0;
                        end
                    end
                end
                RELOAD_REG_OFS: nxt_st.reload = req.data;
                default: ;
            endcase
        end
        // reads, unmapped reads return zero
        nxt_st.rdata = 32'h0000_0000;
        if (req.rd) begin
            case (req.ofs)
                ADDR_REG_OFS: nxt_st.rdata = {25'h0, st_ff.addr};
                BYTE_PORT_OFS: begin
                    nxt_st.rdata = {24'h0, mem_ff[st_ff.addr]};
                    nxt_st.addr = st_ff.addr + 7'h01;
                end
                CONTROL_REG_OFS: nxt_st.rdata = {24'h0, st_ff.ctrl[7:1], 1'b0};
                RELOAD_REG_OFS: nxt_st.rdata = {24'h0, st_ff.reload};
                COUNT_REG_OFS: nxt_st.rdata = {24'h0, st_ff.count};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.ctrl <= CONTROL_RESET;
            st_ff.addr <= ADDR_RESET;
            st_ff.reload <= RELOAD_RESET;
            st_ff.phase <= PH_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // array commits at phase ends; erase clears flagged bytes, write ORs latches
    always_ff @(posedge clk_i) begin
        if (st_ff.running && tick && st_ff.count == 8'h00) begin
            for (int i = 0; i < 4; i++) begin
                if (st_ff.flags[i]) begin
                    if (st_ff.phase == PH_ERASE) begin
                        mem_ff[page_byte(st_ff.addr, 2'(i))] <= 8'h00;
                    end else if (st_ff.phase == PH_WRITE) begin
                        mem_ff[page_byte(st_ff.addr, 2'(i))] <=
                            mem_ff[page_byte(st_ff.addr, 2'(i))] | st_ff.latch[i];
                    end
                end
            end
        end
    end

    assign dat_o = st_ff.rdata;
    assign ack_o = st_ff.ack;
    assign timer_irq_o = st_ff.irq;
    assign busy_o = st_ff.ctrl[IN_PROG_POS];
endmodule // eeprom_page_sequencer_timer

// File: verification/eeprom_page_sequencer_timer_sva.sv
// port-level assertions for the eeprom page sequencer
`timescale 1ns/1ps
module eeprom_page_sequencer_timer_sva
    import eeprom_seq_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // status
    input wire logic deriv_irq_enable_i,
    input wire logic timer_irq_o,
    input wire logic busy_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
logic ctl_wr;
logic rel_wr;
logic [7:0] rel_ff;
logic ien_ff;
logic ew_ff;
int busy_cnt;
int ph;
// shadow of reload and last control word, so cycle length is known
assign ctl_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == CONTROL_REG_OFS;
assign rel_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == RELOAD_REG_OFS;
assign ph = (int'(rel_ff) + 1) * PRESCALE_DIV * (ew_ff ? 2 : 1);
always_ff @(posedge clk_i) begin
    busy_cnt <= busy_o ? busy_cnt + 1 : 0;
    if (rst_i)
        rel_ff <= RELOAD_RESET;
    else if (rel_wr)
        rel_ff <= dat_i[7:0];
    if (ctl_wr) begin
        ien_ff <= dat_i[IRQ_EN_POS];
        ew_ff <= dat_i[3:1] == OP_ERASE_WRITE;
    end
end
property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
a_ack: assert property (p_ack) else $error("ack not one pulse");
property p_inc; ctl_wr && dat_i[7:0] == 8'h04 |=> !busy_o [*2]; endproperty
a_inc: assert property (p_inc) else $error("increment word started a cycle");
property p_wr; ctl_wr && dat_i[IN_PROG_POS] && dat_i[3:1] == OP_WRITE |=> busy_o [*8]; endproperty
a_wr: assert property (p_wr) else $error("write cycle not started");
property p_ew; ctl_wr && dat_i[IN_PROG_POS] && dat_i[3:1] == OP_ERASE_WRITE |=> busy_o [*8];
endproperty
a_ew: assert property (p_ew) else $error("erase/write not started");
property p_er; ctl_wr && dat_i[IN_PROG_POS] && dat_i[3:1] == OP_ERASE |=> busy_o [*8]; endproperty
a_er: assert property (p_er) else $error("erase not started");
property p_cause; $rose(busy_o) |-> $past(ctl_wr && dat_i[IN_PROG_POS]); endproperty
a_cause: assert property (p_cause) else $error("busy without start word");
property p_len; $fell(busy_o) |-> busy_cnt >= ph - 2 && busy_cnt <= ph + 2; endproperty
a_len: assert property (p_len) else $error("cycle length wrong");
property p_irq; $fell(busy_o) && ien_ff && deriv_irq_enable_i |-> ##[0:2] timer_irq_o;
endproperty
a_irq: assert property (p_irq) else $error("no irq at cycle end");
c_ew: cover property ($fell(busy_o) && ew_ff);
c_inc: cover property (ctl_wr && dat_i[7:0] == 8'h04);
c_irq: cover property ($rose(timer_irq_o));
endmodule // eeprom_page_sequencer_timer_sva
bind eeprom_page_sequencer_timer eeprom_page_sequencer_timer_sva u_sva (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .deriv_irq_enable_i(deriv_irq_enable_i),
    .timer_irq_o(timer_irq_o), .busy_o(busy_o));

// File: verification/eeprom_page_sequencer_timer_tb.sv
// self-checking bench for the eeprom page sequencer
`timescale 1ns/1ps
module eeprom_page_sequencer_timer_tb
    import eeprom_seq_pkg::*;
;
logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, den = 1'b0;
logic [7:0] adr = 8'h00;
logic [3:0] sel = 4'h0;
logic [31:0] dat = 32'h0, dato;
logic ack, irq, busy;
int error_cnt = 0, comparisons = 0, cycles = 0, mem[128], lat[4], flg[4];
always #4 clk_i = ~clk_i;
eeprom_page_sequencer_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dato), .ack_o(ack),
    .deriv_irq_enable_i(den), .timer_irq_o(irq), .busy_o(busy));
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
endtask
// slack of two cycles covers where the load edge falls
task automatic chkc(input int e, input int g);
    comparisons++;
    if (g < e - 2 || g > e + 2) begin
        error_cnt++;
        $display("CHECK FAILED cycles expected %0d seen %0d", e, g);
    end
endtask
// one classic cycle, held until ack is sampled
task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dato[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
endtask
task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, e, q);
endtask
task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
// hang guard
always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
        error_cnt++;
        finish_test();
    end
end
initial begin
    int pg, ix, inc, ien, de, cnt, a;
    logic [2:0] op;
    logic [7:0] d, q, rel;
    void'($urandom(32'h24ad));
    foreach (mem[i]) mem[i] = -1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("count", COUNT_REG_OFS, 8'h00);
    rel = 8'($urandom % 3);
    wr(RELOAD_REG_OFS, rel);
    for (int it = 0; it < 12; it++) begin
        op = (it % 3 == 0) ? OP_ERASE : (it % 3 == 1) ? OP_ERASE_WRITE : OP_WRITE;
        pg = $urandom % 4;
        ix = $urandom % 4;
        inc = $urandom % 2;
        lat = '{0, 0, 0, 0};
        flg = '{0, 0, 0, 0};
        if (inc) wr(CONTROL_REG_OFS, 8'h04);
        wr(ADDR_REG_OFS, 8'(pg * 4 + ix));
        repeat (1 + $urandom % 5) begin
            d = 8'($urandom);
            if (!inc) ix = $urandom % 4;
            if (!inc) wr(ADDR_REG_OFS, {1'b0, 5'($urandom), 2'(ix)});
            wr(BYTE_PORT_OFS, d);
            lat[ix] |= d;
            flg[ix] = 1;
            if (inc && ix < 3) ix++;
        end
        if (inc) rdc("index", ADDR_REG_OFS, 8'(pg * 4 + ix));
        else wr(ADDR_REG_OFS, 8'(pg * 4 + ix));
        ien = $urandom % 2;
        de = $urandom % 2;
        den <= 1'(de);
        wr(CONTROL_REG_OFS, {1'b0, 1'(ien), 2'b01, op, 1'b0});
        for (cnt = 2; busy === 1'b1 && cnt < 4000; cnt++) @(posedge clk_i);
        chkc(((op == OP_ERASE_WRITE) ? 2 : 1) * (rel + 1) * PRESCALE_DIV, cnt);
        for (int i = 0; i < 4; i++) begin
            a = pg * 4 + i;
            if (flg[i] && op == OP_ERASE) mem[a] = 0;
            if (flg[i] && op == OP_ERASE_WRITE) mem[a] = lat[i];
            if (flg[i] && op == OP_WRITE && mem[a] >= 0) mem[a] |= lat[i];
        end
        a = (op == OP_ERASE) ? pg * 4 + ix : pg * 4 + ix + 1;
        rdc("address", ADDR_REG_OFS, 8'(a));
        rdc("control", CONTROL_REG_OFS, {1'b0, 1'(ien), 6'h20});
        chk("irq", 8'(ien & de), {7'h0, irq});
        wr(CONTROL_REG_OFS, 8'h00);
        wr(ADDR_REG_OFS, 8'(pg * 4));
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, BYTE_PORT_OFS, 8'h00, q);
            if (mem[pg * 4 + i] >= 0) chk("byte", 8'(mem[pg * 4 + i]), q);
        end
        rdc("read address", ADDR_REG_OFS, 8'(pg * 4 + 8));
        $display("test cycle %0d done", it);
    end
    // free-running timer: start, underflow, stop and hold, restart
    wr(RELOAD_REG_OFS, 8'h02);
    den <= 1'b1;
    wr(CONTROL_REG_OFS, 8'hc0);
    rdc("load", COUNT_REG_OFS, 8'h02);
    repeat (1500) @(posedge clk_i);
    rdc("underflow", CONTROL_REG_OFS, 8'he0);
    chk("free irq", 8'h01, {7'h0, irq});
    wr(CONTROL_REG_OFS, 8'h00);
    wb(1'b0, COUNT_REG_OFS, 8'h00, q);
    repeat (600) @(posedge clk_i);
    wr(COUNT_REG_OFS, 8'hff);
    rdc("held", COUNT_REG_OFS, q);
    wr(CONTROL_REG_OFS, 8'h80);
    rdc("restart", COUNT_REG_OFS, 8'h02);
    rdc("unmapped", 8'h00, 8'h00);
    $display("test free run done");
    finish_test();
end
endmodule // eeprom_page_sequencer_timer_tb
